// file: io_port_defs.svh
// ============================================================
// Purpose: Constants for the bytewise I/O port block
// Assumes: Byte-wide data-space accesses, one per cycle
// Notes:   Addresses are data-space byte addresses
// Operation
// - Each port has data, direction and option registers, bit n for line n.
// - Direction bit picks input (0) or output (1) per line.
// - Input codes: pull-up, hi-z, pull-up with interrupt, analog where supported.
// - Output: option 0 open-drain, 1 push-pull; data bit gives driven value.
// - Reading data of an input line returns the live pin level.
// - Data writes always update the latch, also for input lines.
// - Reset clears all port registers except port C data and option, which go to FFh.
// - Port C analog code selects LCD segment output, one segment per line.
// - Port C lines leave reset in LCD segment mode.
// - Interrupt-selected inputs go to the interrupt system, trigger kept outside.
// - Serial in and clock feed the SPI as inputs, always readable; the block feeds the SPI high while the line is an output.
// - Serial out carries SPI data only when open-drain.
// - Port registers are read and written like RAM in data space.
// - Direction registers sit at C4h, C5h and C6h for ports A, B, C.
`ifndef IO_PORT_DEFS_SVH
`define IO_PORT_DEFS_SVH
`define PORT_NUM      3
`define LINES_PER     8
`define LCD_PORT      2
`define ADDR_DATA_A   8'hc0
`define ADDR_DATA_B   8'hc1
`define ADDR_DATA_C   8'hc3
`define ADDR_DIR_A    8'hc4
`define ADDR_DIR_B    8'hc5
`define ADDR_DIR_C    8'hc6
`define ADDR_OPT_A    8'hcc
`define ADDR_OPT_B    8'hcd
`define ADDR_OPT_C    8'hcf
`define RST_CLEAR     8'h00
`define RST_LCD_SEL   8'hff
`define RDATA_UNMAP   8'h00
`define IDX_SCLK      13
`define IDX_SIN       14
`define IDX_SOUT      15
`endif

// file: io_port_pkg.sv
// ============================================================
// Purpose: Types for the bytewise I/O port block
// Assumes: Constants live in io_port_defs.svh
// Notes:   Mode codes follow a Gray walk from reset mode outward
package io_port_pkg;

  // One port's register triple
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] opt;
  } port_regs_s;

  // Decoded configuration of one line
  typedef enum logic [2:0] {
    MODE_PULLUP = 3'h0,
    MODE_HIZ    = 3'h1,
    MODE_INT    = 3'h3,
    MODE_ANALOG = 3'h2,
    MODE_OD     = 3'h6,
    MODE_PP     = 3'h7,
    MODE_LCD    = 3'h5
  } line_mode_e;

endpackage

// file: io_port_block.sv
// ============================================================
// Purpose: Three bytewise I/O ports with per-line mode selection
// Assumes: Pins are asynchronous; LCD and SPI logic share clock
// Notes:   Line i is port i/8, bit i%8; all outputs registered
`include "io_port_defs.svh"

module io_port_block
  import io_port_pkg::*;
#(
  parameter logic [23:0] ANALOG_MASK = 24'h000fff
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic [23:0] pin_in,
  output logic      [23:0] pin_out,
  output logic      [23:0] pin_oe,
  output logic      [23:0] pullup_en,
  output logic      [23:0] analog_sel,
  output logic      [23:0] int_line,
  output logic      [7:0]  lcd_seg_en,
  input  wire logic [7:0]  lcd_seg_drive,
  input  wire logic        spi_tx,
  output logic             spi_sin,
  output logic             spi_sclk
);

  localparam int NLINES = `PORT_NUM * `LINES_PER;

  // ============================================================
  // Parameter check
  // Combiport lines reuse the analog code for LCD, so no analog there
  if (ANALOG_MASK[23:16] != 8'h00) begin : g_bad_mask
    $error("Analog mask must be zero on the combiport lines");
  end

  // ============================================================
  // Pin synchroniser
  logic [NLINES-1:0] pin_meta_r;
  logic [NLINES-1:0] pin_sync_r;

  // Two stages; only the second stage is read by logic
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ============================================================
  // Register file
  port_regs_s regs_r   [`PORT_NUM];
  port_regs_s regs_nxt [`PORT_NUM];
  logic [7:0] rdata_nxt;

  // Input lines read the pin, output lines read the latch
  function automatic logic [7:0] data_view(port_regs_s r, logic [7:0] lvl);
    data_view = (r.data & r.dir) | (lvl & ~r.dir);
  endfunction

  // Write and read decode; plain RAM-like byte access
  always_comb begin
    for (int p = 0; p < `PORT_NUM; p++) begin
      regs_nxt[p] = regs_r[p];
    end
    rdata_nxt = `RDATA_UNMAP;
    if (bus_wr) begin
      if (bus_addr == `ADDR_DATA_A) begin
        regs_nxt[0].data = bus_wdata;
      end else if (bus_addr == `ADDR_DATA_B) begin
        regs_nxt[1].data = bus_wdata;
      end else if (bus_addr == `ADDR_DATA_C) begin
        regs_nxt[2].data = bus_wdata;
      end else if (bus_addr == `ADDR_DIR_A) begin
        regs_nxt[0].dir = bus_wdata;
      end else if (bus_addr == `ADDR_DIR_B) begin
        regs_nxt[1].dir = bus_wdata;
      end else if (bus_addr == `ADDR_DIR_C) begin
        regs_nxt[2].dir = bus_wdata;
      end else if (bus_addr == `ADDR_OPT_A) begin
        regs_nxt[0].opt = bus_wdata;
      end else if (bus_addr == `ADDR_OPT_B) begin
        regs_nxt[1].opt = bus_wdata;
      end else if (bus_addr == `ADDR_OPT_C) begin
        regs_nxt[2].opt = bus_wdata;
      end
    end
    if (bus_rd) begin
      if (bus_addr == `ADDR_DATA_A) begin
        rdata_nxt = data_view(regs_r[0], pin_sync_r[7:0]);
      end else if (bus_addr == `ADDR_DATA_B) begin
        rdata_nxt = data_view(regs_r[1], pin_sync_r[15:8]);
      end else if (bus_addr == `ADDR_DATA_C) begin
        rdata_nxt = data_view(regs_r[2], pin_sync_r[23:16]);
      end else if (bus_addr == `ADDR_DIR_A) begin
        rdata_nxt = regs_r[0].dir;
      end else if (bus_addr == `ADDR_DIR_B) begin
        rdata_nxt = regs_r[1].dir;
      end else if (bus_addr == `ADDR_DIR_C) begin
        rdata_nxt = regs_r[2].dir;
      end else if (bus_addr == `ADDR_OPT_A) begin
        rdata_nxt = regs_r[0].opt;
      end else if (bus_addr == `ADDR_OPT_B) begin
        rdata_nxt = regs_r[1].opt;
      end else if (bus_addr == `ADDR_OPT_C) begin
        rdata_nxt = regs_r[2].opt;
      end
    end
  end

  // Reset: ports A and B cleared, port C lands in LCD mode
  always_ff @(posedge clock) begin
    if (srst) begin
      regs_r[0] <= '{data: `RST_CLEAR, dir: `RST_CLEAR, opt: `RST_CLEAR};
      regs_r[1] <= '{data: `RST_CLEAR, dir: `RST_CLEAR, opt: `RST_CLEAR};
      regs_r[2] <= '{data: `RST_LCD_SEL, dir: `RST_CLEAR, opt: `RST_LCD_SEL};
      bus_rdata <= `RDATA_UNMAP;
    end else begin
      for (int p = 0; p < `PORT_NUM; p++) begin
        regs_r[p] <= regs_nxt[p];
      end
      bus_rdata <= rdata_nxt;
    end
  end

  // ============================================================
  // Line mode decode
  logic [NLINES-1:0] out_nxt;
  logic [NLINES-1:0] oe_nxt;
  logic [NLINES-1:0] pu_nxt;
  logic [NLINES-1:0] ana_nxt;
  logic [NLINES-1:0] int_nxt;
  logic [7:0]        lcd_nxt;
  logic              sin_nxt;
  logic              sclk_nxt;

  // Per line: direction, option and data bits pick one mode
  always_comb begin
    int         i;
    logic       d;
    logic       o;
    logic       r;
    line_mode_e m;
    i        = 0;
    d        = 1'b0;
    o        = 1'b0;
    r        = 1'b0;
    m        = MODE_PULLUP;
    out_nxt  = '0;
    oe_nxt   = '0;
    pu_nxt   = '0;
    ana_nxt  = '0;
    int_nxt  = '1;
    lcd_nxt  = '0;
    for (int p = 0; p < `PORT_NUM; p++) begin
      for (int b = 0; b < `LINES_PER; b++) begin
        i = p * `LINES_PER + b;
        d = regs_r[p].data[b];
        o = regs_r[p].opt[b];
        r = regs_r[p].dir[b];
        if (r) begin
          m = o ? MODE_PP : MODE_OD;
        end else begin
          case ({o, d})
            2'b00: m = MODE_PULLUP;
            2'b01: m = MODE_HIZ;
            2'b10: m = MODE_INT;
            default: m = (p == `LCD_PORT) ? MODE_LCD : MODE_ANALOG;
          endcase
        end
        case (m)
          MODE_PULLUP: begin
            pu_nxt[i] = 1'b1;
          end
          MODE_INT: begin
            pu_nxt[i]  = 1'b1;
            int_nxt[i] = pin_sync_r[i];
          end
          MODE_ANALOG: begin
            // Lines without a converter input just float
            ana_nxt[i] = ANALOG_MASK[i];
          end
          MODE_OD: begin
            out_nxt[i] = 1'b0;
            oe_nxt[i]  = ~d;
            if (i == `IDX_SOUT) begin
              // Either the latch or the SPI may pull low
              oe_nxt[i] = ~(d & spi_tx);
            end
          end
          MODE_PP: begin
            out_nxt[i] = d;
            oe_nxt[i]  = 1'b1;
          end
          MODE_LCD: begin
            lcd_nxt[b] = 1'b1;
            out_nxt[i] = lcd_seg_drive[b];
            oe_nxt[i]  = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
    // SPI slave inputs; idle high while the line is an output
    sin_nxt  = regs_r[1].dir[`IDX_SIN - `LINES_PER] ? 1'b1 : pin_sync_r[`IDX_SIN];
    sclk_nxt = regs_r[1].dir[`IDX_SCLK - `LINES_PER] ? 1'b1 : pin_sync_r[`IDX_SCLK];
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pullup_en  <= '0;
      analog_sel <= '0;
      int_line   <= '1;
      lcd_seg_en <= '0;
      spi_sin    <= 1'b1;
      spi_sclk   <= 1'b1;
    end else begin
      pin_out    <= out_nxt;
      pin_oe     <= oe_nxt;
      pullup_en  <= pu_nxt;
      analog_sel <= ana_nxt;
      int_line   <= int_nxt;
      lcd_seg_en <= lcd_nxt;
      spi_sin    <= sin_nxt;
      spi_sclk   <= sclk_nxt;
    end
  end

  // ============================================================
  // Checks
  chk_reset_state : assert property (
    @(posedge clock) srst |=> (regs_r[0] == '0) && (regs_r[1] == '0)
      && (regs_r[2].dir == '0) && (regs_r[2].opt == '1) && (regs_r[2].data == '1))
    else $error("Register reset values wrong");

  chk_lcd_reset : assert property (
    @(posedge clock) srst ##1 (!srst && !bus_wr) |=> (lcd_seg_en == 8'hff)
      && (pullup_en[7:0] == 8'hff))
    else $error("Reset did not leave port C in LCD mode");

  chk_input_read : assert property (
    @(posedge clock) disable iff (srst)
      (bus_rd && bus_addr == `ADDR_DATA_A && regs_r[0].dir == 8'h00)
      |=> bus_rdata == $past(pin_sync_r[7:0]))
    else $error("Input line read did not return pin level");

  chk_latch_write : assert property (
    @(posedge clock) disable iff (srst)
      (bus_wr && bus_addr == `ADDR_DATA_B) |=> regs_r[1].data == $past(bus_wdata))
    else $error("Data write did not reach latch");

  chk_dir_addr : assert property (
    @(posedge clock) disable iff (srst)
      (bus_wr && bus_addr == `ADDR_DIR_C) ##1 !bus_wr ##1 (bus_rd && bus_addr == `ADDR_DIR_C)
      |=> bus_rdata == $past(bus_wdata, 3))
    else $error("Direction C write and readback disagree");

  chk_push_pull : assert property (
    @(posedge clock) disable iff (srst)
      (regs_r[0].dir[0] && regs_r[0].opt[0]) |=> pin_oe[0] && pin_out[0] == $past(regs_r[0].data[0]))
    else $error("Push-pull line not driving latch value");

  chk_open_drain : assert property (
    @(posedge clock) disable iff (srst)
      (regs_r[0].dir[1] && !regs_r[0].opt[1]) |=> !pin_out[1] && pin_oe[1] == !$past(regs_r[0].data[1]))
    else $error("Open-drain line drives wrong level");

  chk_pullup_mode : assert property (
    @(posedge clock) disable iff (srst)
      (!regs_r[0].dir[2] && regs_r[0].data[2]) |=> !pullup_en[2] && !pin_oe[2])
    else $error("Hi-z or analog input has pull-up or drive");

  chk_int_route : assert property (
    @(posedge clock) disable iff (srst)
      (!regs_r[1].dir[0] && regs_r[1].opt[0] && !regs_r[1].data[0])
      |=> int_line[8] == $past(pin_sync_r[8]))
    else $error("Interrupt line does not follow pin");

  chk_spi_out : assert property (
    @(posedge clock) disable iff (srst)
      (regs_r[1].dir[7] && !regs_r[1].opt[7])
      |=> pin_oe[`IDX_SOUT] == !($past(regs_r[1].data[7]) && $past(spi_tx)))
    else $error("Serial out not carrying SPI data");

  chk_spi_in : assert property (
    @(posedge clock) disable iff (srst)
      !regs_r[1].dir[6] |=> spi_sin == $past(pin_sync_r[`IDX_SIN]))
    else $error("Serial in not passed to SPI");

  chk_lcd_code : assert property (
    @(posedge clock) disable iff (srst)
      (!regs_r[2].dir[3] && regs_r[2].opt[3] && regs_r[2].data[3])
      |=> lcd_seg_en[3] && !analog_sel[19] && pin_out[19] == $past(lcd_seg_drive[3]))
    else $error("Combiport LCD code not honoured");

endmodule

// file: pin_board_model.sv
// ============================================================
// Purpose: Board side of the 24 port pins
// Assumes: Block drive wins over board drive
// Notes:   Undriven lines without pull-up toggle every cycle
module pin_board_model (
  input  wire logic        clock,
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pullup_en,
  input  wire logic [23:0] ext_val,
  input  wire logic [23:0] ext_en,
  output logic      [23:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic float_r = 1'b0;

  // A floating wire holds no level, so never let it look stable
  always @(posedge clock) float_r <= ~float_r;

  // Resolve each wire from the block, the board and the pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_r;
    end
  end
endmodule

// file: tb_top.sv
// ============================================================
// Purpose: Self-checking bench for the bytewise port block
// Assumes: Inputs change on the falling edge only
// Notes:   Pin effects need two sync edges before a read
`include "io_port_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, srst, bus_wr, bus_rd, spi_tx, spi_sin, spi_sclk;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, lcd_seg_en, lcd_seg_drive;
  logic [23:0] pin_in, pin_out, pin_oe, pullup_en, analog_sel, int_line;
  logic [23:0] ext_val, ext_en;
  int          bad_count, n_tests, cycles;

  io_port_block i_dut (.clock(clock), .srst(srst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .analog_sel(analog_sel), .int_line(int_line), .lcd_seg_en(lcd_seg_en),
    .lcd_seg_drive(lcd_seg_drive), .spi_tx(spi_tx), .spi_sin(spi_sin),
    .spi_sclk(spi_sclk));
  pin_board_model i_board (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ============================================================
  // Clock, timeout and closing report
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Whole run is about 120 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ============================================================
  // Bus helpers: strobe for one cycle, data read one cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clock);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clock);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] v;
    logic [7:0] a [5] = '{`ADDR_DIR_A, `ADDR_DIR_B, `ADDR_DIR_C, `ADDR_OPT_A, `ADDR_OPT_B};
    settle(2);
    `CHK(pullup_en[15:0], 16'hffff)
    `CHK(lcd_seg_en, 8'hff)
    `CHK(pin_oe[23:16], 8'hff)
    `CHK(pin_out[23:16], lcd_seg_drive)
    for (int i = 0; i < 5; i++) begin
      rd(a[i], v);
      `CHK(v, 8'h00)
    end
    rd(`ADDR_OPT_C, v);
    `CHK(v, 8'hff)
    $display("test reset done");
  endtask

  task automatic t_modes();
    logic [7:0] v;
    ext_en = 24'h0001ff;
    ext_val = 24'h000000;
    // Analog code on lines 7 and 12; only line 7 has a converter input
    wr(`ADDR_OPT_A, 8'hf0);
    wr(`ADDR_DATA_A, 8'h8c);
    wr(`ADDR_OPT_B, 8'h11);
    wr(`ADDR_DATA_B, 8'h10);
    settle(4);
    `CHK(pullup_en[7:0], 8'h73)
    `CHK(analog_sel[15:0], 16'h0080)
    `CHK(pullup_en[12], 1'b0)
    `CHK(int_line[7:0], 8'h8f)
    `CHK(int_line[15:8], 8'hfe)
    ext_en = 24'h000000;
    wr(`ADDR_DIR_A, 8'hff);
    wr(`ADDR_OPT_A, 8'h0f);
    wr(`ADDR_DATA_A, 8'ha5);
    settle(2);
    `CHK(pin_oe[7:0], 8'h5f)
    `CHK(pin_out[7:0], 8'h05)
    `CHK(int_line[7:0], 8'hff)
    rd(`ADDR_DATA_A, v);
    `CHK(v, 8'ha5)
    $display("test modes done");
  endtask

  task automatic t_input();
    logic [7:0] v;
    ext_en = 24'h0000ff;
    ext_val = 24'h00003c;
    wr(`ADDR_DIR_A, 8'h00);
    wr(`ADDR_OPT_A, 8'h00);
    wr(`ADDR_DATA_A, 8'hff); // Whole byte, never read-modify-write
    settle(4);
    rd(`ADDR_DATA_A, v);
    `CHK(v, 8'h3c)
    `CHK(pullup_en[7:0], 8'h00)
    wr(`ADDR_DIR_A, 8'hff);
    ext_en = 24'h000000;
    rd(`ADDR_DATA_A, v);
    `CHK(v, 8'hff)
    $display("test input done");
  endtask

  task automatic t_spi();
    logic [7:0] v;
    ext_en = 24'h006000;
    ext_val = 24'h002000;
    wr(`ADDR_DIR_B, 8'h00);
    wr(`ADDR_OPT_B, 8'h00);
    wr(`ADDR_DATA_B, 8'h20);
    settle(4);
    `CHK({spi_sin, spi_sclk}, 2'b01)
    rd(`ADDR_DATA_B, v);
    `CHK(v[6:5], 2'b01)
    wr(`ADDR_DIR_B, 8'h80);
    wr(`ADDR_DATA_B, 8'h80);
    settle(2);
    `CHK(pin_oe[15], 1'b1)
    spi_tx = 1'b1;
    settle(2);
    `CHK(pin_oe[15], 1'b0)
    wr(`ADDR_OPT_B, 8'h80);
    spi_tx = 1'b0;
    settle(2);
    `CHK({pin_oe[15], pin_out[15]}, 2'b11)
    wr(`ADDR_DIR_B, 8'he0);
    ext_en = 24'h000000;
    settle(3);
    `CHK({spi_sin, spi_sclk}, 2'b11)
    $display("test serial done");
  endtask

  task automatic t_map();
    logic [7:0] v;
    wr(`ADDR_DATA_C, 8'h0f);
    settle(2);
    `CHK(lcd_seg_en, 8'h0f)
    wr(8'hc7, 8'hff);
    rd(8'hc7, v);
    `CHK(v, 8'h00)
    rd(8'hc2, v);
    `CHK(v, 8'h00)
    wr(`ADDR_DIR_C, 8'ha5);
    rd(`ADDR_DIR_C, v);
    `CHK(v, 8'ha5)
    rd(`ADDR_DIR_B, v);
    `CHK(v, 8'he0)
    $display("test map done");
  endtask

  // Mid-run reset must undo everything the earlier tests wrote
  task automatic t_rereset();
    srst = 1'b1;
    settle(2);
    srst = 1'b0;
    t_reset();
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    spi_tx = 1'b0;
    lcd_seg_drive = 8'h3c;
    ext_val = 24'h000000;
    ext_en = 24'h000000;
    repeat (6) @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_modes();
    t_input();
    t_spi();
    t_map();
    t_rereset();
    end_of_test();
  end
endmodule
